// ===== design/swc_pkg.sv
// package: register map, field positions and types of the sleep/wake controller
package swc_pkg;
  localparam logic [7:0] SWC_ADDR_STATUS = 8'h03;
  localparam logic [7:0] SWC_ADDR_CM1 = 8'h08;
  localparam logic [7:0] SWC_ADDR_CM2 = 8'h0B;
  localparam logic [7:0] SWC_ADDR_PORTB = 8'h06;
  localparam logic [7:0] SWC_ADDR_WDTCFG = 8'h10;
  localparam logic [7:0] SWC_ADDR_IRQ_STAT = 8'h11;
  localparam logic [7:0] SWC_ADDR_IRQ_EN = 8'h12;
  localparam logic [7:0] SWC_ADDR_IRQ_CLR = 8'h13;
  // status register bit positions
  localparam int SWC_ST_PINWU = 7;
  localparam int SWC_ST_CMPWU = 6;
  localparam int SWC_ST_TO = 4;
  localparam int SWC_ST_PD = 3;
  // comparator control bit positions
  localparam int SWC_CM_OUT = 7;
  localparam int SWC_CM_WU = 0;
  localparam logic [6:0] SWC_CM_RST = 7'h7F;
  // watchdog config bit positions
  localparam int SWC_WC_EN = 0;
  localparam int SWC_WC_PSA = 1;
  localparam int SWC_WC_PINWU_N = 2;
  localparam int SWC_WC_MCLRE = 3;
  localparam logic [3:0] SWC_WC_RST = 4'h9;
  // interrupt event bit positions
  localparam int SWC_EV_SLEEP = 0;
  localparam int SWC_EV_WAKE = 1;
  localparam int SWC_EV_WDT = 2;
  localparam int SWC_EV_W = 3;
  // watchdog period: 18 ms at 10 MHz, prescaler width
  localparam int SWC_CLK_HZ = 10_000_000;
  localparam int SWC_WDT_MS = 18;
  localparam int SWC_WDT_CYC = SWC_CLK_HZ / 1000 * SWC_WDT_MS;
  localparam int SWC_PRE_W = 3;

  typedef enum logic [2:0] {
    SWC_RUN = 3'b001,
    SWC_SLEEP = 3'b010,
    SWC_RESET = 3'b100
  } swc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swc_bus_t;

  typedef struct packed {
    logic sleep;
    logic clear_watchdog_instruction;
  } swc_instr_t;

  typedef struct packed {
    logic [3:0] pins;
    logic [1:0] cmp;
  } swc_sense_t;
endpackage

// ===== design/swc_sync.sv
// module: two-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module swc_sync #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== design/swc_top.sv
// module: sleep entry, wake detection, cause flags and register port
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
// What this block does
// RQ1 - only the sleep instruction enters power-down
// RQ2 - sleep clears watchdog, sets timeout, clears powerdown; a watchdog timeout in the same cycle clears the timeout flag instead
// RQ3 - pins hold their drive state during sleep
// RQ4 - watchdog reset never pulls reset pin
// RQ5 - reset pin wakes when configured as reset
// RQ6 - watchdog timeout wakes when watchdog enabled
// RQ7 - port pin change wakes when enabled
// RQ8 - comparator output change wakes when enabled
// RQ9 - every wake issues a full device reset
// RQ10 - watchdog wake clears the timeout flag
// RQ11 - powerdown flag set at power-up, cleared by sleep
// RQ12 - comparator change in sleep sets comparator flag
// RQ13 - pin change in sleep sets pin flag
// RQ14 - pins compared with levels from last read or write
// RQ15 - comparator compared with value at last read
// RQ16 - software reads pins and comparators before sleeping
// RQ17 - every wake clears the watchdog count
// RQ18 - clear-watchdog zeroes count, prescaler, sets both flags; a timeout or sleep in the same cycle clears its flag instead
// RQ19 - pins and comparators synchronised before comparing
module swc_top
  import swc_pkg::*;
#(
  parameter int WDT_PERIOD = SWC_WDT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input swc_pkg::swc_bus_t bus,
  output logic [7:0] rdata,
  input swc_pkg::swc_instr_t instr,
  input swc_pkg::swc_sense_t sense,
  input wire logic ext_reset_n,
  input wire logic [5:0] io_out,
  input wire logic [5:0] io_oe_n,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_n,
  output logic reset_pin_drive_oe_n,
  output logic osc_drive_en,
  output logic device_reset,
  output logic asleep,
  output logic irq
);
  import swc_pkg::*;

  swc_state_t state_r;
  swc_sense_t sync_s;
  logic [3:0] pin_ref_r;
  logic [1:0] cmp_ref_r;
  logic pinwu_r, cmpwu_r, to_n_r, pd_n_r;
  logic [6:0] cm1_r, cm2_r;
  logic [3:0] wcfg_r;
  logic [SWC_EV_W-1:0] ev_stat_r, ev_en_r, ev_set;
  logic wdt_to, wdt_clr, in_sleep, go_sleep;
  logic pin_chg, cmp_chg, rst_wake, wdt_wake, any_wake;

  // reference capture: pin reads and writes, and comparator control reads
  function automatic logic is_rd(swc_bus_t b, logic [7:0] a);
    return b.rd && (b.addr == a);
  endfunction

  function automatic logic is_wr(swc_bus_t b, logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  swc_sync #(.W($bits(swc_sense_t))) u_sync (
    .clk(clk),
    .srst(srst),
    .d(sense),
    .q(sync_s)
  ); // [RQ19]

  assign in_sleep = (state_r == SWC_SLEEP);
  assign go_sleep = (state_r == SWC_RUN) && instr.sleep; // [RQ1]
  assign pin_chg = !wcfg_r[SWC_WC_PINWU_N] && (sync_s.pins != pin_ref_r); // [RQ7] [RQ14]
  assign cmp_chg = (!cm1_r[SWC_CM_WU] && (sync_s.cmp[0] != cmp_ref_r[0]))
                || (!cm2_r[SWC_CM_WU] && (sync_s.cmp[1] != cmp_ref_r[1])); // [RQ8] [RQ15]
  assign rst_wake = wcfg_r[SWC_WC_MCLRE] && !ext_reset_n; // [RQ5]
  assign wdt_wake = wcfg_r[SWC_WC_EN] && wdt_to; // [RQ6]
  assign any_wake = in_sleep && (rst_wake || wdt_wake || pin_chg || cmp_chg);
  // watchdog cleared on sleep entry, on every wake and by clear instruction
  assign wdt_clr = go_sleep || any_wake || instr.clear_watchdog_instruction; // [RQ2] [RQ17] [RQ18]

  swc_wdt #(.PERIOD(WDT_PERIOD)) u_wdt (
    .clk(clk),
    .srst(srst),
    .enable(wcfg_r[SWC_WC_EN]),
    .use_pre(wcfg_r[SWC_WC_PSA]),
    .clear(wdt_clr),
    .clear_pre(instr.clear_watchdog_instruction),
    .timeout(wdt_to)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= SWC_RUN;
    else
    begin
      case (state_r)
        SWC_RUN:
          if (go_sleep)
            state_r <= SWC_SLEEP; // [RQ1]
        SWC_SLEEP:
          if (any_wake)
            state_r <= SWC_RESET; // [RQ9]
        SWC_RESET:
          state_r <= SWC_RUN;
        default:
          state_r <= SWC_RUN;
      endcase
    end
  end

  // wake always produces a one-cycle device reset
  always_ff @(posedge clk)
  begin
    if (srst)
      device_reset <= 1'b0;
    else
      device_reset <= any_wake || (!in_sleep && wdt_wake); // [RQ9]
  end

  // watchdog reset is internal: reset pin driver never enabled
  always_ff @(posedge clk)
  begin
    reset_pin_drive_oe_n <= 1'b1; // [RQ4]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      osc_drive_en <= 1'b1;
      asleep <= 1'b0;
    end
    else
    begin
      osc_drive_en <= !(go_sleep || (in_sleep && !any_wake)); // [RQ2]
      asleep <= go_sleep || (in_sleep && !any_wake);
    end
  end

  // pin drive frozen while asleep
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end
    else if (!(go_sleep || in_sleep))
    begin
      pin_out <= io_out;
      pin_oe_n <= io_oe_n;
    end
  end // [RQ3]

  always_ff @(posedge clk)
  begin
    if (srst)
      pin_ref_r <= '0;
    else if (is_rd(bus, SWC_ADDR_PORTB) || is_wr(bus, SWC_ADDR_PORTB))
      pin_ref_r <= sync_s.pins; // [RQ14]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cmp_ref_r <= '0;
    else
    begin
      if (is_rd(bus, SWC_ADDR_CM1))
        cmp_ref_r[0] <= sync_s.cmp[0]; // [RQ15]
      if (is_rd(bus, SWC_ADDR_CM2))
        cmp_ref_r[1] <= sync_s.cmp[1]; // [RQ15]
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cm1_r <= SWC_CM_RST;
      cm2_r <= SWC_CM_RST;
      wcfg_r <= SWC_WC_RST;
    end
    else
    begin
      if (is_wr(bus, SWC_ADDR_CM1))
        cm1_r <= bus.wdata[6:0];
      if (is_wr(bus, SWC_ADDR_CM2))
        cm2_r <= bus.wdata[6:0];
      if (is_wr(bus, SWC_ADDR_WDTCFG))
        wcfg_r <= bus.wdata[3:0];
    end
  end

  // timeout flag; srst stands for power-up
  always_ff @(posedge clk)
  begin
    if (srst)
      to_n_r <= 1'b1;
    else if (wdt_to && wcfg_r[SWC_WC_EN])
      to_n_r <= 1'b0; // [RQ10]
    else if (go_sleep)
      to_n_r <= 1'b1; // [RQ2]
    else if (instr.clear_watchdog_instruction)
      to_n_r <= 1'b1; // [RQ18]
  end

  // powerdown flag: sleep clears it even when a timeout lands in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      pd_n_r <= 1'b1; // [RQ11]
    else if (go_sleep)
      pd_n_r <= 1'b0; // [RQ2] [RQ11]
    else if (instr.clear_watchdog_instruction)
      pd_n_r <= 1'b1; // [RQ18]
  end

  // wake cause flags: set on sleep change, cleared on new sleep entry
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pinwu_r <= 1'b0;
      cmpwu_r <= 1'b0;
    end
    else if (any_wake)
    begin
      pinwu_r <= pin_chg; // [RQ13]
      cmpwu_r <= cmp_chg; // [RQ12]
    end
    else if (go_sleep)
    begin
      pinwu_r <= 1'b0;
      cmpwu_r <= 1'b0;
    end
  end

  assign ev_set = {wdt_wake, any_wake, go_sleep};

  always_ff @(posedge clk)
  begin
    if (srst)
      ev_stat_r <= '0;
    else if (is_wr(bus, SWC_ADDR_IRQ_CLR))
      ev_stat_r <= (ev_stat_r & ~bus.wdata[SWC_EV_W-1:0]) | ev_set;
    else
      ev_stat_r <= ev_stat_r | ev_set;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ev_en_r <= '0;
    else if (is_wr(bus, SWC_ADDR_IRQ_EN))
      ev_en_r <= bus.wdata[SWC_EV_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |((ev_stat_r | ev_set) & ev_en_r);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= '0;
    else if (bus.rd)
    begin
      case (bus.addr)
        SWC_ADDR_STATUS:
          rdata <= {pinwu_r, cmpwu_r, 1'b0, to_n_r, pd_n_r, 3'h0};
        SWC_ADDR_CM1:
          rdata <= {sync_s.cmp[0], cm1_r};
        SWC_ADDR_CM2:
          rdata <= {sync_s.cmp[1], cm2_r};
        SWC_ADDR_PORTB:
          rdata <= {4'h0, sync_s.pins};
        SWC_ADDR_WDTCFG:
          rdata <= {4'h0, wcfg_r};
        SWC_ADDR_IRQ_STAT:
          rdata <= {5'h00, ev_stat_r};
        SWC_ADDR_IRQ_EN:
          rdata <= {5'h00, ev_en_r};
        default:
          rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  sleep_only_a: assert property (@(posedge clk) disable iff (srst) // [RQ1]
    (state_r == SWC_RUN) && !instr.sleep |=> state_r != SWC_SLEEP)
    else $error("sleep entered without instruction");
  sleep_flags_a: assert property (@(posedge clk) disable iff (srst) // [RQ2]
    go_sleep && !(wdt_to && wcfg_r[SWC_WC_EN]) |=> !pd_n_r && to_n_r && !osc_drive_en)
    else $error("sleep entry flags wrong");
  pins_hold_a: assert property (@(posedge clk) disable iff (srst) // [RQ3]
    in_sleep && $past(in_sleep) |=> $stable(pin_out) && $stable(pin_oe_n))
    else $error("pins changed in sleep");
  rst_pin_a: assert property (@(posedge clk) disable iff (srst) // [RQ4]
    wdt_to |=> reset_pin_drive_oe_n)
    else $error("reset pin driven");
  wake_reset_a: assert property (@(posedge clk) disable iff (srst) // [RQ9]
    any_wake |=> device_reset && state_r == SWC_RESET ##1 state_r == SWC_RUN)
    else $error("wake without reset");
  wdt_flag_a: assert property (@(posedge clk) disable iff (srst) // [RQ10]
    in_sleep && wdt_wake |=> !to_n_r && device_reset)
    else $error("timeout flag not cleared");
  pin_flag_a: assert property (@(posedge clk) disable iff (srst) // [RQ13]
    in_sleep && pin_chg |=> pinwu_r)
    else $error("pin wake flag missing");
  cmp_flag_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    in_sleep && cmp_chg |=> cmpwu_r)
    else $error("comparator wake flag missing");
  ext_wake_a: assert property (@(posedge clk) disable iff (srst) // [RQ5]
    in_sleep && rst_wake |=> !asleep)
    else $error("reset pin did not wake");
  clr_flags_a: assert property (@(posedge clk) disable iff (srst) // [RQ18]
    instr.clear_watchdog_instruction && !go_sleep && !wdt_to |=> to_n_r && pd_n_r)
    else $error("clear watchdog flags wrong");
  pd_clear_a: assert property (@(posedge clk) disable iff (srst) // [RQ11]
    go_sleep |=> !pd_n_r)
    else $error("powerdown flag not cleared by sleep");
  wake_wdt_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ17]
    any_wake |=> u_wdt.cnt_r == '0)
    else $error("watchdog count not cleared on wake");
  wdt_wake_a: assert property (@(posedge clk) disable iff (srst) // [RQ6]
    in_sleep && wdt_wake |=> !asleep && osc_drive_en)
    else $error("watchdog timeout did not wake");

  wdt_wake_c: cover property (@(posedge clk) in_sleep && wdt_wake);
  pin_wake_c: cover property (@(posedge clk) in_sleep && pin_chg);
  cmp_wake_c: cover property (@(posedge clk) in_sleep && cmp_chg);
  ext_wake_c: cover property (@(posedge clk) in_sleep && rst_wake);
  sleep_c: cover property (@(posedge clk) go_sleep);
endmodule

// ===== design/swc_wdt.sv
// module: watchdog counter with optional prescaler and synchronous clear
`timescale 1ns/1ps
module swc_wdt
  import swc_pkg::*;
#(
  parameter int PERIOD = SWC_WDT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic use_pre,
  input wire logic clear,
  input wire logic clear_pre,
  output logic timeout
);
  localparam int CW = $clog2(PERIOD + 1);
  logic [CW-1:0] cnt_r;
  logic [SWC_PRE_W-1:0] pre_r;
  logic tick;

  assign tick = !use_pre || (pre_r == '1);

  always_ff @(posedge clk)
  begin
    if (srst || clear_pre || !use_pre)
      pre_r <= '0;
    else if (enable)
      pre_r <= pre_r + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    timeout <= 1'b0;
    if (srst || clear || !enable)
      cnt_r <= '0;
    else if (tick)
    begin
      if (cnt_r == CW'(PERIOD - 1))
      begin
        cnt_r <= '0;
        timeout <= 1'b1;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// ===== sim/swc_far.sv
// far-side model: port pins, comparator outputs and the pulled-up reset pin
`timescale 1ns/1ps
module swc_far #(
  parameter int LAT = 2
) (
  input wire logic clk,
  input wire logic [5:0] lvl,
  input wire logic rst_req,
  output swc_pkg::swc_sense_t sense,
  output logic ext_reset_n
);
  import swc_pkg::*;
  // levels reach the pins some cycles after they are asked for
  logic [6:0] dly [LAT] = '{default: 7'h00};

  always @(posedge clk)
  begin
    dly[0] <= {rst_req, lvl};
    for (int i = 1; i < LAT; i++)
      dly[i] <= dly[i-1];
  end

  assign sense = dly[LAT-1][5:0];
  // pull-up keeps the reset pin high unless a reset is asked for
  assign ext_reset_n = ~dly[LAT-1][6];
endmodule

// ===== sim/swc_top_tb.sv
// testbench: sleep entry, wake sources, cause flags, registers and interrupt
`timescale 1ns/1ps
module swc_top_tb;
  import swc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  swc_bus_t bus = '0;
  swc_instr_t instr = '0;
  logic [5:0] io_out = '0;
  logic [5:0] io_oe_n = '1;
  logic [5:0] lvl;
  logic rst_req = 1'b0;
  swc_sense_t sense;
  logic ext_reset_n;
  logic [7:0] rdata;
  logic [5:0] pin_out;
  logic [5:0] pin_oe_n;
  logic rpin_oe_n;
  logic osc_en;
  logic dev_rst;
  logic asleep;
  logic irq;
  logic rd_q = 1'b0;
  logic [7:0] exp_q [$];
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #50 clk = ~clk;

  swc_top #(.WDT_PERIOD(20)) i_dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
    .instr(instr), .sense(sense), .ext_reset_n(ext_reset_n), .io_out(io_out),
    .io_oe_n(io_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .reset_pin_drive_oe_n(rpin_oe_n), .osc_drive_en(osc_en), .device_reset(dev_rst),
    .asleep(asleep), .irq(irq));
  swc_far #(.LAT(2)) i_far (.clk(clk), .lvl(lvl), .rst_req(rst_req), .sense(sense),
    .ext_reset_n(ext_reset_n));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_lvl(input logic got, input logic exp);
    chk_data({7'h00, got}, {7'h00, exp});
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_q <= bus.rd;
    if (rd_q)
      chk_data(rdata, exp_q.pop_front());
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask

  task automatic pulse(input logic slp);
    @(posedge clk);
    instr <= '{sleep: slp, clear_watchdog_instruction: !slp};
    @(posedge clk);
    instr <= '0;
  endtask

  task automatic wait_wake(input int max, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (max)
    begin
      @(posedge clk);
      if (dev_rst === 1'b1)
        seen = 1'b1;
      if (seen)
        break;
    end
    chk_lvl(seen, exp);
  endtask

  // kind: 0 pin change, 1 comparator one, 2 reset pin, 3 watchdog, 4 comparator two
  task automatic nap(input int kind, input logic [7:0] st);
    logic [5:0] io_sv;
    logic [5:0] oe_sv;
    wr(SWC_ADDR_WDTCFG, (kind == 3) ? 8'h09 : 8'h08);
    pulse(1'b0);
    wr(SWC_ADDR_CM1, {7'h3F, kind != 1});
    wr(SWC_ADDR_CM2, {7'h3F, kind != 4});
    rd(SWC_ADDR_PORTB, {4'h0, lvl[5:2]});
    rd(SWC_ADDR_CM1, {lvl[0], 6'h3F, kind != 1});
    rd(SWC_ADDR_CM2, {lvl[1], 6'h3F, kind != 4});
    io_sv = 6'($urandom);
    oe_sv = 6'($urandom);
    io_out <= io_sv;
    io_oe_n <= oe_sv;
    pulse(1'b1);
    io_out <= ~io_sv;
    io_oe_n <= ~oe_sv;
    @(posedge clk);
    chk_lvl(asleep, 1'b1);
    chk_lvl(osc_en, 1'b0);
    rd(SWC_ADDR_STATUS, 8'h10);
    chk_data({2'b00, pin_out}, {2'b00, io_sv});
    chk_data({2'b00, pin_oe_n}, {2'b00, oe_sv});
    if (kind == 0)
      lvl <= lvl ^ 6'(6'h04 << ($urandom % 4));
    if (kind == 1)
      lvl <= lvl ^ 6'h01;
    if (kind == 4)
      lvl <= lvl ^ 6'h02;
    rst_req <= (kind == 2);
    wait_wake(30, 1'b1);
    rst_req <= 1'b0;
    chk_lvl(asleep, 1'b0);
    chk_lvl(rpin_oe_n, 1'b1);
    rd(SWC_ADDR_STATUS, st);
  endtask

  initial
  begin
    void'($urandom(32'h0285c8e3));
    lvl = 6'($urandom);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(SWC_ADDR_WDTCFG, 8'h09);
    rd(SWC_ADDR_STATUS, 8'h18);
    rd(SWC_ADDR_CM2, {lvl[1], 7'h7F});
    rd(8'h20, 8'h00);
    chk_lvl(osc_en, 1'b1);
    chk_lvl(asleep, 1'b0);
    nap(3, 8'h00);
    nap(1, 8'h50);
    nap(4, 8'h50);
    nap(2, 8'h10);
    nap(0, 8'h90);
    // pins not read again: the next sleep must end at once
    pulse(1'b1);
    wait_wake(8, 1'b1);
    rd(SWC_ADDR_STATUS, 8'h90);
    wr(SWC_ADDR_WDTCFG, 8'h09);
    repeat (3)
    begin
      pulse(1'b0);
      wait_wake(15, 1'b0);
    end
    rd(SWC_ADDR_STATUS, 8'h98);
    wait_wake(25, 1'b1);
    // prescaler by eight: the timeout comes some 160 cycles after the clear
    wr(SWC_ADDR_WDTCFG, 8'h0B);
    pulse(1'b0);
    wait_wake(140, 1'b0);
    wait_wake(40, 1'b1);
    wr(SWC_ADDR_WDTCFG, 8'h08);
    rd(SWC_ADDR_IRQ_STAT, 8'h07);
    wr(SWC_ADDR_IRQ_EN, 8'h00);
    repeat (2) @(posedge clk);
    chk_lvl(irq, 1'b0);
    wr(SWC_ADDR_IRQ_EN, 8'h04);
    repeat (2) @(posedge clk);
    chk_lvl(irq, 1'b1);
    wr(SWC_ADDR_IRQ_CLR, 8'h07);
    repeat (2) @(posedge clk);
    chk_lvl(irq, 1'b0);
    rd(SWC_ADDR_IRQ_STAT, 8'h00);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule
